// ### design/ascc_chan_seq.sv
`timescale 1ns/10ps
`default_nettype none

// Channel index walker for one sample/convert group
module ascc_chan_seq #(
    parameter int IDX_W = 2
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    // Control
    input  wire logic             i_load,
    input  wire logic             i_advance,
    input  wire logic [IDX_W-1:0] i_last_index,
    // Status
    output logic      [IDX_W-1:0] o_index,
    output logic      [IDX_W-1:0] o_next_index,
    output logic                  o_last
);

    logic [IDX_W-1:0] index_reg;
    logic [IDX_W-1:0] index_next;

    // Load restarts at channel zero; advance steps to the next channel and holds at the last index
    always_comb
    begin
        index_next = index_reg;
        if (i_load)
        begin
            index_next = '0;
        end
        else if (i_advance && (index_reg != i_last_index))
        begin
            index_next = index_reg + IDX_W'(1);
        end
    end

    // Index register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            index_reg <= '0;
        end
        else
        begin
            index_reg <= index_next;
        end
    end

    assign o_index      = index_reg;
    assign o_next_index = index_next;
    assign o_last       = (index_reg == i_last_index);

endmodule

`default_nettype wire

// ### design/ascc_ctrl.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

package ascc_pkg;
    // Register offsets
    localparam logic [3:0] OFS_CTRL1  = 4'h0;
    localparam logic [3:0] OFS_ALLOC  = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_MASK   = 4'h3;
    // Control one field positions
    localparam int POS_DONE   = 0;
    localparam int POS_SAMPLE_ENABLE   = 1;
    localparam int POS_SAMPLE_AUTO_START   = 2;
    localparam int POS_SIM    = 3;
    localparam int POS_SRC    = 5;
    localparam int POS_CHANNEL_COUNT_SELECT   = 8;
    localparam int POS_TWELVE = 10;
    // Allocation field and interrupt bits
    localparam int ALLOC_W    = 3;
    localparam int EV_W       = 2;
    localparam int EV_DONE    = 0;
    localparam int EV_SAMPEND = 1;
    // Reset values and codes
    localparam logic [2:0]      SRC_MANUAL  = 3'h0;
    localparam logic [2:0]      ALLOC_RESET = 3'h0;
    localparam logic [EV_W-1:0] MASK_RESET  = 2'h0;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10,
        ST_WAIT   = 2'b11
    } ascc_state_t;
endpackage

module ascc_ctrl #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    output logic      [DATA_W-1:0] o_rd_data,
    // Sample/hold and conversion core
    input  wire logic              i_trigger,
    input  wire logic              i_conv_done,
    output logic      [3:0]        o_acquire,
    output logic                   o_conv_start,
    output logic      [1:0]        o_conv_chan,
    output logic      [7:0]        o_buffer_words,
    // Interrupt
    output logic                   o_irq
);

    // Last channel index for a channel count setting
    function automatic logic [1:0] fn_last_index(input logic [1:0] channel_count_select);
        fn_last_index = channel_count_select[1] ? 2'h3 : (channel_count_select[0] ? 2'h1 : 2'h0);
    endfunction

    // Simultaneous mode only with several channels and not in 12-bit mode
    function automatic logic fn_sim_eff(input logic sim, input logic twelve,
                                        input logic [1:0] channel_count_select);
        fn_sim_eff = sim && !twelve && (channel_count_select != 2'h0);
    endfunction

    // Acquire lines for a sampling phase
    function automatic logic [3:0] fn_acq(input logic sim,
                                          input logic [1:0] channel_count_select,
                                          input logic [1:0] idx);
        if (sim)
        begin
            fn_acq = channel_count_select[1] ? 4'hF : 4'h3;
        end
        else
        begin
            fn_acq = 4'h1 << idx;
        end
    endfunction

    ascc_pkg::ascc_state_t state_reg, state_next;
    logic              done_reg, done_next;
    logic              sample_auto_start_reg, sample_auto_start_next;
    logic              sim_reg, sim_next;
    logic [2:0]        src_reg, src_next;
    logic [1:0]        channel_count_select_reg, channel_count_select_next;
    logic              twelve_reg, twelve_next;
    logic [ascc_pkg::ALLOC_W-1:0] alloc_reg, alloc_next;
    logic [ascc_pkg::EV_W-1:0]    stat_reg, stat_next;
    logic [ascc_pkg::EV_W-1:0]    mask_reg, mask_next;
    logic              irq_reg, irq_next;
    logic [DATA_W-1:0] rd_data_reg, rd_data_next;
    logic [3:0]        acq_reg, acq_next;
    logic              cstart_reg, cstart_next;
    logic [1:0]        cchan_reg, cchan_next;
    logic [7:0]        words_reg, words_next;
    logic              seq_load, seq_adv, seq_last;
    logic [1:0]        seq_idx, seq_idx_next;
    logic              wr_ctrl, wr_alloc, wr_mask, rd_stat;
    logic              sim_eff, ev_done, ev_end;

    assign wr_ctrl  = i_wr_en && (i_addr == ADDR_W'(ascc_pkg::OFS_CTRL1));
    assign wr_alloc = i_wr_en && (i_addr == ADDR_W'(ascc_pkg::OFS_ALLOC));
    assign wr_mask  = i_wr_en && (i_addr == ADDR_W'(ascc_pkg::OFS_MASK));
    assign rd_stat  = i_rd_en && (i_addr == ADDR_W'(ascc_pkg::OFS_STATUS));
    assign sim_eff  = fn_sim_eff(sim_reg, twelve_reg, channel_count_select_reg);

    ascc_chan_seq #(
        .IDX_W (2)
    ) u_seq (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_load       (seq_load),
        .i_advance    (seq_adv),
        .i_last_index (fn_last_index(channel_count_select_reg)),
        .o_index      (seq_idx),
        .o_next_index (seq_idx_next),
        .o_last       (seq_last)
    );

    // Sequencer, control fields and complete flag
    always_comb
    begin
        state_next  = state_reg;
        done_next   = done_reg;
        sample_auto_start_next   = sample_auto_start_reg;
        sim_next    = sim_reg;
        src_next    = src_reg;
        channel_count_select_next   = channel_count_select_reg;
        twelve_next = twelve_reg;
        alloc_next  = alloc_reg;
        mask_next   = mask_reg;
        seq_load    = 1'b0;
        seq_adv     = 1'b0;
        cstart_next = 1'b0;
        cchan_next  = cchan_reg;
        ev_done     = 1'b0;
        ev_end      = 1'b0;
        if (wr_ctrl)
        begin
            sample_auto_start_next   = i_wr_data[ascc_pkg::POS_SAMPLE_AUTO_START];
            sim_next    = i_wr_data[ascc_pkg::POS_SIM];
            src_next    = i_wr_data[ascc_pkg::POS_SRC +: 3];
            channel_count_select_next   = i_wr_data[ascc_pkg::POS_CHANNEL_COUNT_SELECT +: 2];
            twelve_next = i_wr_data[ascc_pkg::POS_TWELVE];
            if (!i_wr_data[ascc_pkg::POS_DONE])
            begin
                done_next = 1'b0;
            end
        end
        if (wr_alloc)
        begin
            alloc_next = i_wr_data[ascc_pkg::ALLOC_W-1:0];
        end
        if (wr_mask)
        begin
            mask_next = i_wr_data[ascc_pkg::EV_W-1:0];
        end
        case (state_reg)
            ascc_pkg::ST_IDLE:
            begin
                // Hold until software sets the enable
                if (wr_ctrl && i_wr_data[ascc_pkg::POS_SAMPLE_ENABLE])
                begin
                    state_next = ascc_pkg::ST_SAMPLE;
                    seq_load   = 1'b1;
                end
            end
            ascc_pkg::ST_SAMPLE:
            begin
                if ((src_reg == ascc_pkg::SRC_MANUAL && wr_ctrl &&
                     !i_wr_data[ascc_pkg::POS_SAMPLE_ENABLE]) ||
                    (src_reg != ascc_pkg::SRC_MANUAL && i_trigger))
                begin
                    state_next = ascc_pkg::ST_CONV;
                    ev_end     = 1'b1;
                end
            end
            ascc_pkg::ST_CONV:
            begin
                cstart_next = 1'b1;
                cchan_next  = seq_idx;
                done_next   = 1'b0;
                state_next  = ascc_pkg::ST_WAIT;
            end
            ascc_pkg::ST_WAIT:
            begin
                if (i_conv_done)
                begin
                    if (seq_last)
                    begin
                        done_next = 1'b1;
                        ev_done   = 1'b1;
                        if (sample_auto_start_reg)
                        begin
                            state_next = ascc_pkg::ST_SAMPLE;
                            seq_load   = 1'b1;
                        end
                        else
                        begin
                            state_next = ascc_pkg::ST_IDLE;
                        end
                    end
                    else
                    begin
                        // Held group converts on; sequential resamples
                        seq_adv    = 1'b1;
                        state_next = sim_eff ? ascc_pkg::ST_CONV
                                             : ascc_pkg::ST_SAMPLE;
                    end
                end
            end
            default:
            begin
                state_next = ascc_pkg::ST_IDLE;
            end
        endcase
    end

    // Outputs, interrupt status and read data
    always_comb
    begin
        stat_next = rd_stat ? '0 : stat_reg;
        stat_next[ascc_pkg::EV_DONE]    = stat_next[ascc_pkg::EV_DONE]
                                          | ev_done;
        stat_next[ascc_pkg::EV_SAMPEND] = stat_next[ascc_pkg::EV_SAMPEND]
                                          | ev_end;
        irq_next = |(stat_next & mask_next);
        acq_next = 4'h0;
        if (state_next == ascc_pkg::ST_SAMPLE)
        begin
            acq_next = fn_acq(fn_sim_eff(sim_next, twelve_next, channel_count_select_next),
                              channel_count_select_next, seq_idx_next);
        end
        words_next   = 8'h01 << alloc_next;
        rd_data_next = '0;
        if (i_rd_en)
        begin
            case (i_addr)
                ADDR_W'(ascc_pkg::OFS_CTRL1):
                begin
                    rd_data_next[ascc_pkg::POS_DONE]   = done_reg;
                    rd_data_next[ascc_pkg::POS_SAMPLE_ENABLE]   =
                        (state_reg == ascc_pkg::ST_SAMPLE);
                    rd_data_next[ascc_pkg::POS_SAMPLE_AUTO_START]   = sample_auto_start_reg;
                    rd_data_next[ascc_pkg::POS_SIM]    =
                        sim_reg && !twelve_reg;
                    rd_data_next[ascc_pkg::POS_SRC +: 3]  = src_reg;
                    rd_data_next[ascc_pkg::POS_CHANNEL_COUNT_SELECT +: 2] = channel_count_select_reg;
                    rd_data_next[ascc_pkg::POS_TWELVE] = twelve_reg;
                end
                ADDR_W'(ascc_pkg::OFS_ALLOC):
                    rd_data_next[ascc_pkg::ALLOC_W-1:0] = alloc_reg;
                ADDR_W'(ascc_pkg::OFS_STATUS):
                    rd_data_next[ascc_pkg::EV_W-1:0] = stat_reg;
                ADDR_W'(ascc_pkg::OFS_MASK):
                    rd_data_next[ascc_pkg::EV_W-1:0] = mask_reg;
                default:
                    rd_data_next = '0; // Unmapped reads as zero
            endcase
        end
    end

    // State registers
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_reg   <= ascc_pkg::ST_IDLE;
            done_reg    <= 1'b0;
            sample_auto_start_reg    <= 1'b0;
            sim_reg     <= 1'b0;
            src_reg     <= ascc_pkg::SRC_MANUAL;
            channel_count_select_reg    <= 2'h0;
            twelve_reg  <= 1'b0;
            alloc_reg   <= ascc_pkg::ALLOC_RESET;
            stat_reg    <= '0;
            mask_reg    <= ascc_pkg::MASK_RESET;
            irq_reg     <= 1'b0;
            rd_data_reg <= '0;
            acq_reg     <= 4'h0;
            cstart_reg  <= 1'b0;
            cchan_reg   <= 2'h0;
            words_reg   <= 8'h01;
        end
        else
        begin
            state_reg   <= state_next;
            done_reg    <= done_next;
            sample_auto_start_reg    <= sample_auto_start_next;
            sim_reg     <= sim_next;
            src_reg     <= src_next;
            channel_count_select_reg    <= channel_count_select_next;
            twelve_reg  <= twelve_next;
            alloc_reg   <= alloc_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            irq_reg     <= irq_next;
            rd_data_reg <= rd_data_next;
            acq_reg     <= acq_next;
            cstart_reg  <= cstart_next;
            cchan_reg   <= cchan_next;
            words_reg   <= words_next;
        end
    end

    assign o_rd_data      = rd_data_reg;
    assign o_acquire      = acq_reg;
    assign o_conv_start   = cstart_reg;
    assign o_conv_chan    = cchan_reg;
    assign o_buffer_words = words_reg;
    assign o_irq          = irq_reg;

    // Checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_manual_end: assert property (
        (state_reg == ascc_pkg::ST_SAMPLE && src_reg == ascc_pkg::SRC_MANUAL
         && wr_ctrl && !i_wr_data[ascc_pkg::POS_SAMPLE_ENABLE])
        |=> (state_reg == ascc_pkg::ST_CONV) ##1 o_conv_start)
        else $error("manual end of sampling did not start conversion");
    a_hw_end: assert property (
        (state_reg == ascc_pkg::ST_SAMPLE && src_reg != ascc_pkg::SRC_MANUAL
         && i_trigger) |=> ##1 (o_conv_start && o_acquire == 4'h0))
        else $error("hardware trigger did not end sampling");
    a_auto_restart: assert property (
        (state_reg == ascc_pkg::ST_WAIT && i_conv_done && seq_last
         && sample_auto_start_reg)
        |=> (state_reg == ascc_pkg::ST_SAMPLE && o_acquire != 4'h0))
        else $error("auto-start did not resume sampling");
    a_done_set: assert property (
        (state_reg == ascc_pkg::ST_WAIT && i_conv_done && seq_last)
        |=> done_reg)
        else $error("complete flag not set at end of conversion");
    a_done_new_conv: assert property (
        o_conv_start |-> !done_reg)
        else $error("complete flag not cleared at conversion start");
    a_done_no_swset: assert property (
        (wr_ctrl && i_wr_data[ascc_pkg::POS_DONE] && !done_reg &&
         !(state_reg == ascc_pkg::ST_WAIT && i_conv_done)) |=> !done_reg)
        else $error("software write of one set the complete flag");
    a_sim_zero_read: assert property (
        (i_rd_en && i_addr == ADDR_W'(ascc_pkg::OFS_CTRL1) && twelve_reg)
        |=> !o_rd_data[ascc_pkg::POS_SIM])
        else $error("simultaneous select read one in 12-bit mode");
    a_seq_single: assert property (
        (state_reg == ascc_pkg::ST_SAMPLE && !sim_eff)
        |-> $onehot(o_acquire))
        else $error("sequential mode acquired more than one channel");
    a_sim_group: assert property (
        (state_reg == ascc_pkg::ST_SAMPLE && sim_eff)
        |-> (o_acquire == (channel_count_select_reg[1] ? 4'hF : 4'h3)))
        else $error("simultaneous group wrong");
    a_sample_enable_read: assert property (
        (i_rd_en && i_addr == ADDR_W'(ascc_pkg::OFS_CTRL1))
        |=> o_rd_data[ascc_pkg::POS_SAMPLE_ENABLE]
            == $past(state_reg == ascc_pkg::ST_SAMPLE))
        else $error("sample enable readback wrong");
    a_alloc_words: assert property (
        o_buffer_words == (8'h01 << alloc_reg))
        else $error("buffer word count mismatch");
    a_alloc_upper: assert property (
        (i_rd_en && i_addr == ADDR_W'(ascc_pkg::OFS_ALLOC))
        |=> o_rd_data[DATA_W-1:ascc_pkg::ALLOC_W] == '0)
        else $error("allocation upper bits not zero");

    c_sim_four: cover property (o_conv_start && o_conv_chan == 2'h3);
    c_auto: cover property (ev_done && sample_auto_start_reg);
    c_hw_trig: cover property (ev_end && src_reg != ascc_pkg::SRC_MANUAL);
    c_irq: cover property (o_irq);

endmodule

`default_nettype wire

// ### verif/ascc_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// Behavioural conversion core: answers each start after a set delay
module ascc_core_model (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // Link from the controller
    input  wire logic       i_conv_start,
    input  wire logic [3:0] i_delay,
    output logic            o_conv_done
);
    int cnt;

    // One conversion outstanding; done never lands in the start cycle
    always_ff @(posedge i_ref_clk)
    begin
        o_conv_done <= 1'b0;
        if (i_rst)
            cnt <= 0;
        else if (i_conv_start)
            cnt <= int'(i_delay) + 1;
        else if (cnt == 1)
        begin
            o_conv_done <= 1'b1;
            cnt <= 0;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule

`default_nettype wire

// ### verif/ascc_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none

module ascc_ctrl_test;
    logic        ref_clk;
    logic        rst;
    logic [3:0]  addr;
    logic [15:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [15:0] rd_data;
    logic        trigger;
    logic        conv_done;
    logic [3:0]  acquire;
    logic        conv_start;
    logic [1:0]  conv_chan;
    logic [7:0]  buffer_words;
    logic        irq;
    logic [3:0]  delay;
    logic [7:0]  chan_log;
    logic [7:0]  n_starts;
    logic [3:0]  acq_seen;
    logic [15:0] rv;
    int          num_errors;
    int          cmp_count;

    ascc_ctrl dut (
        .i_ref_clk(ref_clk), .i_rst(rst), .i_addr(addr),
        .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .o_rd_data(rd_data), .i_trigger(trigger), .i_conv_done(conv_done),
        .o_acquire(acquire), .o_conv_start(conv_start),
        .o_conv_chan(conv_chan), .o_buffer_words(buffer_words), .o_irq(irq)
    );

    ascc_core_model core (
        .i_ref_clk(ref_clk), .i_rst(rst), .i_conv_start(conv_start),
        .i_delay(delay), .o_conv_done(conv_done)
    );

    // Free-running 20 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Log each converted channel and any acquire line left open at a start
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            chan_log <= 8'h00;
            n_starts <= 8'h00;
            acq_seen <= 4'h0;
        end
        else if (conv_start === 1'b1)
        begin
            chan_log <= {chan_log[5:0], conv_chan};
            n_starts <= n_starts + 8'h01;
            acq_seen <= acq_seen | acquire;
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic do_reset(input int n);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rst <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    // Bounded wait: 0 start count, 1 acquire lines, 2 complete flag
    task automatic wait_for(input int sel, input logic [7:0] val);
        logic [7:0] got;
        for (int i = 0; i < 200; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (sel == 2)
                rd(ascc_pkg::OFS_CTRL1, rv);
            got = (sel == 0) ? n_starts : {4'h0, acquire};
            if (sel == 2)
                got = {7'h00, rv[ascc_pkg::POS_DONE]};
            if (got === val)
            begin
                cmp_count++;
                return;
            end
        end
        num_errors++;
        $display("ERROR t=%0t wait ran out", $time);
        results();
    endtask

    function automatic logic [15:0] mk(
        input logic sample_enable, input logic sample_auto_start, input logic sim,
        input logic [2:0] src, input logic [1:0] channel_count_select, input logic twelve);
        logic [15:0] v;
        v = 16'h0000;
        v[ascc_pkg::POS_SAMPLE_ENABLE] = sample_enable;
        v[ascc_pkg::POS_SAMPLE_AUTO_START] = sample_auto_start;
        v[ascc_pkg::POS_SIM] = sim;
        v[ascc_pkg::POS_SRC +: 3] = src;
        v[ascc_pkg::POS_CHANNEL_COUNT_SELECT +: 2] = channel_count_select;
        v[ascc_pkg::POS_TWELVE] = twelve;
        return v;
    endfunction

    task automatic pulse_trigger();
        @(posedge ref_clk);
        trigger <= 1'b1;
        @(posedge ref_clk);
        trigger <= 1'b0;
    endtask

    // Reset values, unmapped place, allocation field and buffer size
    task automatic t_regs();
        rdc(ascc_pkg::OFS_CTRL1, 16'h0000);
        rdc(ascc_pkg::OFS_ALLOC, 16'h0000);
        rdc(4'hF, 16'h0000);
        check({8'h00, buffer_words}, 16'h0001);
        for (int v = 0; v < 8; v++)
        begin
            wr(ascc_pkg::OFS_ALLOC, {13'h1FFF, 3'(v)});
            rdc(ascc_pkg::OFS_ALLOC, {13'h0000, 3'(v)});
            check({8'h00, buffer_words}, 16'h0001 << v);
        end
        $display("t_regs finished");
    endtask

    // Manual group with simultaneous select, complete flag and interrupt
    task automatic t_sim(input logic [1:0] channel_count_select, input logic [3:0] eacq,
                         input logic [7:0] elog, input logic [7:0] en);
        do_reset(2);
        delay <= 4'h0;
        wr(ascc_pkg::OFS_MASK, 16'h0001);
        wr(ascc_pkg::OFS_CTRL1, mk(1, 0, 1, 3'h0, channel_count_select, 0));
        wait_for(1, {4'h0, eacq});
        rdc(ascc_pkg::OFS_CTRL1, mk(1, 0, 1, 3'h0, channel_count_select, 0));
        wr(ascc_pkg::OFS_CTRL1, mk(0, 0, 1, 3'h0, channel_count_select, 0));
        wait_for(2, 8'h01);
        check({8'h00, chan_log}, {8'h00, elog});
        check({8'h00, n_starts}, {8'h00, en});
        check({12'h000, acq_seen}, 16'h0000);
        check({12'h000, acquire}, 16'h0000);
        check({15'h0000, irq}, 16'h0001);
        rdc(ascc_pkg::OFS_STATUS, 16'h0003);
        @(posedge ref_clk);
        #1 check({15'h0000, irq}, 16'h0000);
        wr(ascc_pkg::OFS_CTRL1, mk(0, 0, 1, 3'h0, channel_count_select, 0) | 16'h0001);
        rdc(ascc_pkg::OFS_CTRL1, mk(0, 0, 1, 3'h0, channel_count_select, 0) | 16'h1);
        wr(ascc_pkg::OFS_CTRL1, mk(0, 0, 1, 3'h0, channel_count_select, 0));
        rdc(ascc_pkg::OFS_CTRL1, mk(0, 0, 1, 3'h0, channel_count_select, 0));
        // A one written over a clear flag must not set it
        wr(ascc_pkg::OFS_CTRL1, mk(0, 0, 1, 3'h0, channel_count_select, 0) | 16'h1);
        rdc(ascc_pkg::OFS_CTRL1, mk(0, 0, 1, 3'h0, channel_count_select, 0));
        $display("t_sim finished");
    endtask

    // Sequential mode: channel one resampled on its own, slow core
    task automatic t_seq();
        do_reset(2);
        delay <= 4'h5;
        wr(ascc_pkg::OFS_CTRL1, mk(1, 0, 0, 3'h0, 2'b01, 0));
        wait_for(1, 8'h01);
        wr(ascc_pkg::OFS_CTRL1, mk(0, 0, 0, 3'h0, 2'b01, 0));
        wait_for(1, 8'h02);
        check({8'h00, n_starts}, 16'h0001);
        wr(ascc_pkg::OFS_CTRL1, mk(0, 0, 0, 3'h0, 2'b01, 0));
        wait_for(2, 8'h01);
        check({8'h00, chan_log}, 16'h0001);
        check({15'h0000, irq}, 16'h0000);
        $display("t_seq finished");
    endtask

    // Hardware trigger, auto-start, flag cleared by a new conversion
    task automatic t_auto();
        do_reset(2);
        delay <= 4'h9;
        wr(ascc_pkg::OFS_CTRL1, mk(1, 1, 1, 3'h1, 2'b10, 0));
        wait_for(1, 8'h0F);
        pulse_trigger();
        wait_for(0, 8'h01);
        rdc(ascc_pkg::OFS_CTRL1, mk(0, 1, 1, 3'h1, 2'b10, 0));
        wait_for(2, 8'h01);
        wait_for(1, 8'h0F);
        rdc(ascc_pkg::OFS_CTRL1, mk(1, 1, 1, 3'h1, 2'b10, 0) | 16'h1);
        pulse_trigger();
        wait_for(0, 8'h05);
        rdc(ascc_pkg::OFS_CTRL1, mk(0, 1, 1, 3'h1, 2'b10, 0));
        do_reset(2);
        wr(ascc_pkg::OFS_CTRL1, mk(0, 0, 1, 3'h0, 2'b10, 1));
        rdc(ascc_pkg::OFS_CTRL1, mk(0, 0, 0, 3'h0, 2'b10, 1));
        $display("t_auto finished");
    endtask

    // Main sequence
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        addr = 4'h0;
        wr_data = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        trigger = 1'b0;
        delay = 4'h0;
        do_reset(7); // Leading edge plus seven: eight edges in reset
        t_regs();
        t_sim(2'b00, 4'h1, 8'h00, 8'h01);
        t_sim(2'b01, 4'h3, 8'h01, 8'h02);
        t_sim(2'b10, 4'hF, 8'h1B, 8'h04);
        t_sim(2'b11, 4'hF, 8'h1B, 8'h04);
        t_seq();
        t_auto();
        results();
    end
endmodule

`default_nettype wire
